// File: core/sadc_conv.v
// SAR converter conversion control and serial result readout core.
// Assumes an APB master on pclk; strobe, shift clock, echo pin and
// analog code arrive from outside the pclk domain.
//
// Local design decisions: the address map and register access over APB.
`default_nettype none
`include "sadc_regs.vh"

module sadc_conv (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire strobe_p,
  input wire strobe_n,
  input wire [15:0] analog_in,
  input wire shift_clk_in,
  input wire echo_clk_i,
  output reg echo_clk_o,
  output reg echo_clk_oe,
  output reg serial_data_out,
  output reg powered_down
);

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam [7:0] READY_CYC = `SADC_RESULT_READY_CYC;
  localparam [7:0] CUTOFF_CYC = `SADC_CLOCK_CUTOFF_CYC;
  localparam [7:0] ACQ_CYC = `SADC_ACQ_CYC;
  localparam [2:0] STRAP_CYC = `SADC_STRAP_CYC;

  // Conversion states
  localparam [1:0] ST_ACQ = 2'h0;
  localparam [1:0] ST_IDLE = 2'h1;
  localparam [1:0] ST_CONV = 2'h2;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg [2:0] ctrl_reg;
  reg lost_reg;
  reg [15:0] last_reg;
  reg [1:0] state_reg;
  reg [7:0] timer_reg;
  reg sar_done_reg;
  reg [15:0] sar_word_reg;
  reg push_reg;
  reg [1:0] strb_s1_reg;
  reg [1:0] strb_s2_reg;
  reg strb_prev_reg;
  reg clk_s1_reg;
  reg clk_s2_reg;
  reg clk_s3_reg;
  reg echo_s1_reg;
  reg echo_s2_reg;
  reg [2:0] strap_cnt_reg;
  reg strap_done_reg;
  reg self_mode_reg;
  reg [15:0] ain_s1_reg;
  reg [15:0] ain_s2_reg;
  reg [18:0] shreg_reg;
  reg [4:0] bits_left_reg;
  reg quiet_reg;
  wire wr_en;
  wire rd_en;
  wire pdown;
  wire strobe_lvl;
  wire strobe_rise;
  wire start;
  wire sar_done;
  wire [15:0] sar_result;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [15:0] fifo_out_data;
  wire load_word;
  wire clk_fall;
  wire cutoff_hit;
  wire ready_hit;
  wire abort_word;
  wire push_lost;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Zero wait states; unmapped offsets answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && (paddr != `SADC_CTRL_OFS)
    && (paddr != `SADC_STATUS_OFS) && (paddr != `SADC_RESULT_OFS);
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !pwrite;

  // Control register and sticky lost flag; set beats clear
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= `SADC_CTRL_RST;
      lost_reg <= 1'b0;
    end
    else
    begin
      if (wr_en && paddr == `SADC_CTRL_OFS)
        ctrl_reg <= pwdata[2:0];
      if (abort_word || push_lost)
        lost_reg <= 1'b1;
      else if (wr_en && paddr == `SADC_STATUS_OFS && pwdata[`SADC_ST_LOST_BIT])
        lost_reg <= 1'b0;
    end
  end

  // Read data registered in the setup cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd_en && !penable)
    begin
      case (paddr)
        `SADC_CTRL_OFS: prdata <= {29'h0, ctrl_reg};
        `SADC_STATUS_OFS: prdata <= {25'h0, (bits_left_reg != 5'h00),
          !fifo_in_ready, !fifo_out_valid, lost_reg, self_mode_reg,
          pdown, (state_reg == ST_CONV)};
        `SADC_RESULT_OFS: prdata <= {16'h0, last_reg};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Two flops on every outside pin before any logic
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strb_s1_reg <= 2'h0;
      strb_s2_reg <= 2'h0;
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      clk_s3_reg <= 1'b0;
      echo_s1_reg <= 1'b0;
      echo_s2_reg <= 1'b0;
      ain_s1_reg <= 16'h0000;
      ain_s2_reg <= 16'h0000;
      strb_prev_reg <= 1'b0;
    end
    else
    begin
      strb_s1_reg <= {strobe_n, strobe_p};
      strb_s2_reg <= strb_s1_reg;
      clk_s1_reg <= shift_clk_in;
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
      echo_s1_reg <= echo_clk_i;
      echo_s2_reg <= echo_s1_reg;
      ain_s1_reg <= analog_in;
      ain_s2_reg <= ain_s1_reg;
      strb_prev_reg <= strobe_lvl;
    end
  end

  // Single-ended level on positive pin, or the pair's difference
  assign strobe_lvl = ctrl_reg[`SADC_CTRL_LVDS_BIT]
    ? (strb_s2_reg[0] && !strb_s2_reg[1]) : strb_s2_reg[0];
  assign strobe_rise = strobe_lvl && !strb_prev_reg;
  assign clk_fall = clk_s3_reg && !clk_s2_reg;

  // ----------------------------------------------------------------
  // Readout mode strap
  // ----------------------------------------------------------------
  // Echo pin left undriven after reset; a grounded pin means self-clocked
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_cnt_reg <= 3'h0;
      strap_done_reg <= 1'b0;
      self_mode_reg <= 1'b0;
    end
    else if (!strap_done_reg)
    begin
      strap_cnt_reg <= strap_cnt_reg + 3'h1;
      if (strap_cnt_reg == STRAP_CYC)
      begin
        strap_done_reg <= 1'b1;
        self_mode_reg <= !echo_s2_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Conversion control
  // ----------------------------------------------------------------
  assign pdown = !ctrl_reg[`SADC_CTRL_REF0_BIT] && !ctrl_reg[`SADC_CTRL_REF1_BIT];
  assign start = (state_reg == ST_IDLE) && strobe_rise && !pdown;
  assign cutoff_hit = (state_reg == ST_CONV) && (timer_reg == CUTOFF_CYC);
  assign ready_hit = (state_reg == ST_CONV) && (timer_reg >= READY_CYC);
  assign push_lost = push_reg && !fifo_in_ready;

  // Acquire, wait for strobe, convert; strobes inside a conversion do nothing
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= ST_ACQ;
      timer_reg <= 8'h00;
      sar_done_reg <= 1'b0;
      sar_word_reg <= 16'h0000;
      push_reg <= 1'b0;
      last_reg <= 16'h0000;
      quiet_reg <= 1'b0;
    end
    else
    begin
      push_reg <= 1'b0;
      if (sar_done)
      begin
        sar_done_reg <= 1'b1;
        sar_word_reg <= sar_result;
      end
      case (state_reg)
        ST_ACQ:
        begin
          timer_reg <= timer_reg + 8'h01;
          if (timer_reg >= ACQ_CYC)
          begin
            state_reg <= ST_IDLE;
            timer_reg <= 8'h00;
          end
        end
        ST_IDLE:
        begin
          if (start)
          begin
            state_reg <= ST_CONV;
            timer_reg <= 8'h00;
            sar_done_reg <= 1'b0;
          end
        end
        ST_CONV:
        begin
          if (timer_reg != 8'hFF)
            timer_reg <= timer_reg + 8'h01;
          if (cutoff_hit)
            quiet_reg <= 1'b1;
          if (ready_hit && sar_done_reg)
          begin
            state_reg <= ST_ACQ;
            timer_reg <= 8'h00;
            push_reg <= 1'b1;
            last_reg <= sar_word_reg;
            quiet_reg <= 1'b0;
          end
        end
        default:
        begin
          state_reg <= ST_ACQ;
          timer_reg <= 8'h00;
        end
      endcase
    end
  end

  // Sixteen-step approximation of the held sample
  sadc_sar u_sar (
    .clk(pclk),
    .rstn(presetn),
    .start(start),
    .sample(ain_s2_reg),
    .done(sar_done),
    .result(sar_result)
  );

  // Results wait here until the serialiser is free
  sadc_fifo #(
    .W(16),
    .D(4),
    .AW(2)
  ) u_fifo (
    .clk(pclk),
    .rstn(presetn),
    .in_valid(push_reg),
    .in_ready(fifo_in_ready),
    .in_data(last_reg),
    .out_valid(fifo_out_valid),
    .out_ready(load_word),
    .out_data(fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Serial readout
  // ----------------------------------------------------------------
  // Load only when idle, outside the quiet window, while the shift clock is low
  assign load_word = fifo_out_valid && (bits_left_reg == 5'h00)
    && !quiet_reg && !clk_s2_reg && !pdown;
  assign abort_word = cutoff_hit && (bits_left_reg != 5'h00);

  // Shift on each falling edge of the host clock
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shreg_reg <= 19'h00000;
      bits_left_reg <= 5'h00;
    end
    else if (abort_word)
    begin
      shreg_reg <= 19'h00000;
      bits_left_reg <= 5'h00;
    end
    else if (load_word)
    begin
      if (self_mode_reg)
      begin
        shreg_reg <= {`SADC_HEADER, fifo_out_data};
        bits_left_reg <= 5'd19;
      end
      else
      begin
        shreg_reg <= {fifo_out_data, 3'h0};
        bits_left_reg <= 5'd16;
      end
    end
    else if (clk_fall && bits_left_reg != 5'h00)
    begin
      shreg_reg <= {shreg_reg[17:0], 1'b0};
      bits_left_reg <= bits_left_reg - 5'h01;
    end
  end

  // Pin drivers: data and echo held low in the quiet window
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      serial_data_out <= 1'b0;
      echo_clk_o <= 1'b0;
      echo_clk_oe <= 1'b0;
      powered_down <= 1'b0;
    end
    else
    begin
      powered_down <= pdown;
      echo_clk_oe <= strap_done_reg && !self_mode_reg;
      echo_clk_o <= clk_s2_reg && !quiet_reg && !self_mode_reg;
      if (quiet_reg || cutoff_hit || bits_left_reg == 5'h00)
        serial_data_out <= 1'b0;
      else
        serial_data_out <= shreg_reg[18];
    end
  end

endmodule // sadc_conv

`default_nettype wire

// File: core/sadc_regs.vh
// Constants for the SAR converter conversion and serial readout core.
// Assumes a 250 MHz pclk and an APB master with 32-bit data.
`ifndef SADC_REGS_VH
`define SADC_REGS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define SADC_CTRL_OFS 8'h00
`define SADC_STATUS_OFS 8'h04
`define SADC_RESULT_OFS 8'h08

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define SADC_CTRL_REF0_BIT 0
`define SADC_CTRL_REF1_BIT 1
`define SADC_CTRL_LVDS_BIT 2
`define SADC_CTRL_RST 3'h3
`define SADC_ST_BUSY_BIT 0
`define SADC_ST_PDOWN_BIT 1
`define SADC_ST_SELFCLK_BIT 2
`define SADC_ST_LOST_BIT 3
`define SADC_ST_EMPTY_BIT 4
`define SADC_ST_FULL_BIT 5
`define SADC_ST_SHIFT_BIT 6
`define SADC_SIGN_FLIP 16'h8000
`define SADC_HEADER 3'h2

// ----------------------------------------------------------------
// Timing: times in ns, counts in pclk cycles
// ----------------------------------------------------------------
`define SADC_CLK_PERIOD_NS 4
`define SADC_RESULT_READY_NS 100
`define SADC_CLOCK_CUTOFF_NS 20
`define SADC_ACQ_NS 20
`define SADC_STRAP_CYC 4
`define SADC_RESULT_READY_CYC \
  ((`SADC_RESULT_READY_NS + `SADC_CLK_PERIOD_NS - 1) / `SADC_CLK_PERIOD_NS)
`define SADC_CLOCK_CUTOFF_CYC (`SADC_CLOCK_CUTOFF_NS / `SADC_CLK_PERIOD_NS)
`define SADC_ACQ_CYC ((`SADC_ACQ_NS + `SADC_CLK_PERIOD_NS - 1) / `SADC_CLK_PERIOD_NS)

`endif

// File: core/sadc_fifo.v
// Small result FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`default_nettype none

module sadc_fifo #(
  parameter W = 16,
  parameter D = 4,
  parameter AW = 2
) (
  input wire clk,
  input wire rstn,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);

  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;

  // Honest full and empty from the fill count
  assign in_ready = (count_reg != D);
  assign out_valid = (count_reg != 0);
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage array
  always @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end

  // Pointers and fill count
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end

endmodule // sadc_fifo

`default_nettype wire

// File: core/sadc_sar.v
// Successive-approximation stepper, one bit per clock.
// Assumes the held sample stays steady for the whole conversion.
`default_nettype none
`include "sadc_regs.vh"

module sadc_sar (
  input wire clk,
  input wire rstn,
  input wire start,
  input wire [15:0] sample,
  output reg done,
  output reg [15:0] result
);

  reg [15:0] target_reg;
  reg [15:0] code_reg;
  reg [15:0] bit_reg;
  reg run_reg;
  wire [15:0] trial;

  // Trial code: decided bits plus the bit under test
  assign trial = code_reg | bit_reg;

  // Sixteen steps, MSB first, in offset binary
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      target_reg <= 16'h0000;
      code_reg <= 16'h0000;
      bit_reg <= 16'h0000;
      run_reg <= 1'b0;
      done <= 1'b0;
      result <= 16'h0000;
    end
    else
    begin
      done <= 1'b0;
      if (start && !run_reg)
      begin
        target_reg <= sample ^ `SADC_SIGN_FLIP;
        code_reg <= 16'h0000;
        bit_reg <= 16'h8000;
        run_reg <= 1'b1;
      end
      else if (run_reg)
      begin
        if (trial <= target_reg)
          code_reg <= trial;
        bit_reg <= bit_reg >> 1;
        if (bit_reg == 16'h0001)
        begin
          run_reg <= 1'b0;
          done <= 1'b1;
          result <= (trial <= target_reg ? trial : code_reg) ^ `SADC_SIGN_FLIP;
        end
      end
    end
  end

endmodule // sadc_sar

`default_nettype wire

// File: test/sadc_conv_properties.sv
// Concurrent checks on the converter core, bound to its ports.
// Assumes one pclk domain and the active-low asynchronous reset.
`default_nettype none

module sadc_conv_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic shift_clk_in,
  input wire logic echo_clk_o,
  input wire logic echo_clk_oe,
  input wire logic serial_data_out,
  input wire logic powered_down
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // --------------------------------------------------------------
  // Access and link sequences
  // --------------------------------------------------------------
  sequence ctrl_wr;
    psel && penable && pwrite && paddr == 8'h00;
  endsequence
  sequence echo_rise;
    $rose(echo_clk_o);
  endsequence
  a_pd_enter: assert property (ctrl_wr ##0 pwdata[1:0] == 2'b00 |-> ##[1:3] powered_down)
    else $error("power-down not entered");
  a_pd_leave: assert property (ctrl_wr ##0 pwdata[1:0] != 2'b00 |-> ##[1:3] !powered_down)
    else $error("power-down not left");
  a_pd_hold: assert property (powered_down && !$past(psel && penable && pwrite) |=> powered_down)
    else $error("power-down dropped by itself");
  a_ready_const: assert property (pready)
    else $error("pready low");
  a_bad_addr: assert property (psel && penable && paddr > 8'h08 |-> pslverr)
    else $error("unmapped access not refused");
  a_good_addr: assert property (psel && penable && paddr[1:0] == 2'b00 && paddr <= 8'h08
    |-> !pslverr) else $error("mapped access refused");
  a_self_quiet: assert property (!echo_clk_oe |-> !echo_clk_o)
    else $error("echo toggles while pin not driven");
  a_echo_follow: assert property (echo_clk_oe && $rose(shift_clk_in) |-> ##[1:5] echo_clk_o)
    else $error("echo does not follow shift clock");
  a_data_on_fall: assert property (echo_rise |-> ##1 $stable(serial_data_out) [*2])
    else $error("data moved near echo rise");
endmodule // sadc_conv_properties

bind sadc_conv sadc_conv_properties i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .shift_clk_in(shift_clk_in), .echo_clk_o(echo_clk_o),
  .echo_clk_oe(echo_clk_oe), .serial_data_out(serial_data_out),
  .powered_down(powered_down));

`default_nettype wire

// File: test/sadc_host_model.sv
// Host shift-register model: bursts the shift clock and collects bits.
// Assumes the core's serial outputs; clock idles low outside bursts.
`default_nettype none

module sadc_host_model (
  input wire logic pclk,
  input wire logic self_mode,
  input wire logic serial_data_out,
  input wire logic echo_clk_o,
  output logic shift_clk_in,
  output logic [18:0] word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic echo_q;
  logic take = 1'b0;
  logic clear = 1'b0;
  initial shift_clk_in <= 1'b0;
  // --------------------------------------------------------------
  // Capture on echo rising edge, or on own strobe in self mode
  // --------------------------------------------------------------
  always @(posedge pclk)
  begin
    echo_q <= echo_clk_o;
    if (clear)
      word <= 19'h00000;
    else if (self_mode ? take : (echo_clk_o && !echo_q))
      word <= {word[17:0], serial_data_out};
  end
  // Burst n pulses, half pclk cycles per phase, then stand still
  task automatic burst(input int n, input int half);
    clear <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      @(posedge pclk);
      clear <= 1'b0;
      shift_clk_in <= 1'b1;
      repeat (half - 1) @(posedge pclk);
      take <= self_mode;
      @(posedge pclk);
      take <= 1'b0;
      shift_clk_in <= 1'b0;
      repeat (half - 1) @(posedge pclk);
    end
    repeat (8) @(posedge pclk);
  endtask
endmodule // sadc_host_model

`default_nettype wire

// File: test/tb_top.sv
// Testbench for the converter core: APB tasks, strobes and host bursts.
// Assumes the core, its FIFO and SAR modules and the host model.
`default_nettype none

`define CHK(a, e) \
  begin \
    comparisons++; \
    if ((a) !== (e)) \
    begin \
      miscompares++; \
      $display("BAD t=%0t got %h want %h", $time, a, e); \
    end \
  end

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  int miscompares = 0;
  int comparisons = 0;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, strobe_p, strobe_n, strap, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, q;
  logic [15:0] analog_in;
  logic [15:0] codes [6] = '{16'h0000, 16'h7FFF, 16'h8000, 16'hFFFF, 16'h0001, 16'h8001};
  wire logic [31:0] prdata;
  wire logic pready, pslverr, shift_clk_in, echo_pin, echo_clk_o, echo_clk_oe;
  wire logic serial_data_out, powered_down;
  wire logic [18:0] word;

  sadc_conv i_sadc_conv (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .strobe_p(strobe_p), .strobe_n(strobe_n), .analog_in(analog_in),
    .shift_clk_in(shift_clk_in), .echo_clk_i(echo_pin), .echo_clk_o(echo_clk_o),
    .echo_clk_oe(echo_clk_oe), .serial_data_out(serial_data_out),
    .powered_down(powered_down));
  sadc_host_model i_host (.pclk(pclk), .self_mode(!strap), .serial_data_out(serial_data_out),
    .echo_clk_o(echo_clk_o), .shift_clk_in(shift_clk_in), .word(word));

  assign echo_pin = echo_clk_oe ? echo_clk_o : strap;
  initial forever #2 pclk = ~pclk;

  // --------------------------------------------------------------
  // Access tasks
  // --------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse();
    @(posedge pclk);
    strobe_p <= 1'b1;
    strobe_n <= 1'b0;
    repeat (3) @(posedge pclk);
    strobe_p <= 1'b0;
    strobe_n <= 1'b1;
  endtask
  task automatic convert(input logic [15:0] code, input int n, input int half);
    analog_in <= code;
    pulse();
    repeat (40) @(posedge pclk);
    i_host.burst(n, half);
    `CHK(word, {(n == 19) ? 3'b010 : 3'b000, code})
    apb(1'b0, 8'h08, 32'h0);
    `CHK(q, {16'h0000, code})
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (12) @(posedge pclk);
  endtask
  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watchdog cuts a hang short
  initial
  begin
    #60000;
    miscompares++;
    stop_test();
  end

  initial
  begin
    {psel, penable, pwrite, strobe_p} <= 4'h0;
    {strobe_n, strap, paddr, pwdata, analog_in} <= {2'b11, 56'h0};
    do_reset();
    apb(1'b0, 8'h00, 32'h0);
    `CHK(q, 32'h00000003)
    apb(1'b0, 8'h04, 32'h0);
    `CHK(q, 32'h00000010)
    apb(1'b1, 8'h0C, 32'hFFFFFFFF);
    `CHK(err, 1'b1)
    apb(1'b0, 8'h0C, 32'h0);
    `CHK(q, 32'h00000000)
    $display("registers done");
    foreach (codes[i])
    begin
      if (i == 5)
        apb(1'b1, 8'h00, 32'h00000007);
      convert(codes[i], 16, 4);
    end
    apb(1'b1, 8'h00, 32'h00000003);
    $display("codes done");
    analog_in <= 16'h1234;
    pulse();
    analog_in <= 16'h4321;
    repeat (8) @(posedge pclk);
    pulse();
    repeat (40) @(posedge pclk);
    i_host.burst(16, 4);
    `CHK(word, {3'b000, 16'h1234})
    apb(1'b0, 8'h04, 32'h0);
    `CHK(q[4:3], 2'b10)
    analog_in <= 16'h0F0F;
    pulse();
    repeat (40) @(posedge pclk);
    i_host.burst(4, 4);
    pulse();
    repeat (40) @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0);
    `CHK(q[3], 1'b1)
    apb(1'b1, 8'h04, 32'h00000008);
    apb(1'b0, 8'h04, 32'h0);
    `CHK(q[3], 1'b0)
    i_host.burst(16, 4);
    `CHK(word, {3'b000, 16'h0F0F})
    $display("ignore and loss done");
    for (int v = 0; v < 4; v++)
    begin
      apb(1'b1, 8'h00, 32'(v));
      repeat (2) @(posedge pclk);
      `CHK(powered_down, (v == 0))
    end
    apb(1'b1, 8'h00, 32'h0);
    pulse();
    repeat (40) @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0);
    `CHK(q[4:0], 5'h12)
    apb(1'b1, 8'h00, 32'h00000003);
    $display("power-down done");
    strap <= 1'b0;
    do_reset();
    apb(1'b0, 8'h04, 32'h0);
    `CHK(q[2], 1'b1)
    `CHK(echo_clk_oe, 1'b0)
    convert(16'h8001, 19, 4);
    convert(16'h7FFE, 19, 4);
    $display("self-clocked done");
    stop_test();
  end
endmodule // tb_top

`default_nettype wire
